// file: src/ucft_top.sv
// Purpose: Serial transceiver clocking, framing and transmitter with register slave
// Assumes: Avalon-MM master with waitrequest, inputs synchronous to clk
// Notes: Receiver is minimal: one data register, frame error and completion only
//
// Function
// - Double speed divides by 8, not 16
// - Double speed ignored in synchronous modes
// - Double speed receiver counts 8 ticks a bit, one mid-bit sample
// - Slave clock synchronised then edge detected
// - Clock pin output as sync master, input slave
// - Sample on edge opposite to change
// - Polarity picks change and sample edges
// - All thirty frame formats supported
// - Start, data LSB first, parity, stops
// - Start low, stop high, idle high
// - One frame setting for both directions
// - Frame error only from first stop
// - Parity is xor, inverted for odd
// - MSB selects control C or divisor high
// - Transmit enable takes over output pin
// - Data write fills buffer, shifter loads
// - Unused high data bits ignored
// - Baud down-counter reloads on zero, low byte write
// - Buffer empty flag cleared by write
// - Complete flag set after last frame
`default_nettype none
module ucft_top (
   input wire logic clk, // system clock, 10 MHz
   input wire logic nrst, // async reset, active low
   input wire logic [4:0] address, // byte address
   input wire logic read, // read request
   input wire logic write, // write request
   input wire logic [3:0] byteenable, // byte lanes
   input wire logic [31:0] writedata, // write data
   output logic [31:0] readdata, // read data
   output logic waitrequest, // slave stall
   output logic txd_o, // serial output
   output logic txd_oe, // serial output enable
   input wire logic rxd_i, // serial input
   input wire logic tclk_i, // transfer clock pin input
   output logic tclk_o, // transfer clock pin output
   output logic tclk_oe // transfer clock pin enable
);
   function automatic logic [3:0] data_bits(input logic [2:0] sz);
      if (sz == ucft_pkg::SZ_NINE) data_bits = 4'd9;
      else if (sz[2]) data_bits = 4'd8;
      else data_bits = 4'd5 + {2'b00, sz[1:0]};
   endfunction : data_bits

   function automatic logic [8:0] size_mask(input logic [3:0] n);
      size_mask = 9'h1ff >> (4'd9 - n);
   endfunction : size_mask

   logic [7:0] stat_b_q;
   logic [7:0] stat_c_q;
   logic dbl_q;
   logic [11:0] div_q;
   logic txcomp_q;
   logic ferr_q;
   logic rxdone_q;
   logic [8:0] rx_data_q;
   logic [8:0] buf_q;
   logic buf_full_q;
   logic [ucft_pkg::FRAME_W-1:0] sh_q;
   logic [3:0] tx_cnt_q;
   logic [4:0] tx_div_q;
   logic ck_q;
   ucft_pkg::ucft_rx_st_t rx_st_q;
   logic [4:0] rx_ph_q;
   logic [3:0] rx_cnt_q;
   logic [8:0] rx_sh_q;
   logic acc_q;

   // Frame format shared by both directions
   wire [2:0] size = {stat_b_q[ucft_pkg::B_SZ2], stat_c_q[ucft_pkg::C_SZ_HI:ucft_pkg::C_SZ_LO]};
   wire [3:0] nbits = data_bits(size);
   wire par_en = stat_c_q[ucft_pkg::C_PAR_HI];
   wire par_odd = stat_c_q[ucft_pkg::C_PAR_LO];
   wire stop2 = stat_c_q[ucft_pkg::C_STOP2];
   wire sync_mode = stat_c_q[ucft_pkg::C_SYNC];
   wire pol = stat_c_q[ucft_pkg::C_POL];
   wire master = stat_b_q[ucft_pkg::B_MASTER];
   wire transmit_enable_bit = stat_b_q[ucft_pkg::B_TX_ON];
   wire rxen = stat_b_q[ucft_pkg::B_RXEN];
   // Double speed only shortens the asynchronous bit period
   wire [4:0] bit_div = dbl_q ? ucft_pkg::DIV_DOUBLE : ucft_pkg::DIV_NORMAL;

   // Bus decode; an access is taken on the cycle waitrequest is low
   wire req = read | write;
   wire take = req & acc_q;
   wire wr = take & write & byteenable[0];
   wire [7:0] wd = writedata[7:0];
   wire wr_data = wr && (address == ucft_pkg::OFS_DATA);
   wire wr_a = wr && (address == ucft_pkg::OFS_STAT_A);
   wire wr_b = wr && (address == ucft_pkg::OFS_STAT_B);
   wire wr_c = wr && (address == ucft_pkg::OFS_SHARED) && wd[ucft_pkg::C_SEL];
   wire wr_hi = wr && (address == ucft_pkg::OFS_SHARED) && !wd[ucft_pkg::C_SEL];
   wire wr_lo = wr && (address == ucft_pkg::OFS_DIV_LO);
   wire rd_data = take && read && (address == ucft_pkg::OFS_DATA);

   wire [7:0] stat_a = {rxdone_q, txcomp_q, !buf_full_q, ferr_q, 2'b00, dbl_q, 1'b0};
   wire [7:0] stat_b_rd = {stat_b_q[7:2], rx_data_q[8], stat_b_q[0]};
   logic [7:0] rd_mux;
   always_comb begin
      case (address)
         ucft_pkg::OFS_DATA: rd_mux = rx_data_q[7:0];
         ucft_pkg::OFS_STAT_A: rd_mux = stat_a;
         ucft_pkg::OFS_STAT_B: rd_mux = stat_b_rd;
         ucft_pkg::OFS_SHARED: rd_mux = stat_c_q;
         ucft_pkg::OFS_DIV_LO: rd_mux = div_q[7:0];
         default: rd_mux = 8'h00;
      endcase
   end

   // Bit clocks
   logic tick;
   logic x_rise;
   logic x_fall;
   ucft_baud_gen u_baud (
      .clk(clk),
      .nrst(nrst),
      .divisor(div_q),
      .reload(wr_lo),
      .tick(tick)
   );
   ucft_clk_edge u_edge (
      .clk(clk),
      .nrst(nrst),
      .tclk_i(tclk_i),
      .rise(x_rise),
      .fall(x_fall)
   );
   // Master clock toggles per tick: rate is tick / 2
   wire m_chg = tick & (ck_q == pol);
   wire m_smp = tick & (ck_q != pol);
   wire s_chg = pol ? x_fall : x_rise;
   wire s_smp = pol ? x_rise : x_fall;
   wire sync_chg = master ? m_chg : s_chg;
   wire sync_smp = master ? m_smp : s_smp;
   wire async_bit = tick && (tx_div_q == bit_div - 5'd1);
   wire shift_en = sync_mode ? sync_chg : async_bit;

   // Frame build: start, data LSB first, parity, stop bits
   wire [8:0] tx_data = buf_q & size_mask(nbits);
   wire par_bit = (^tx_data) ^ par_odd;
   logic [ucft_pkg::FRAME_W-1:0] frame;
   always_comb begin
      frame = '1;
      frame[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (i < nbits) frame[i + 1] = tx_data[i];
      end
      if (par_en) frame[nbits + 4'd1] = par_bit;
   end
   wire [3:0] frame_len = 4'd2 + nbits + {3'b000, par_en} + {3'b000, stop2};
   wire tx_busy = (tx_cnt_q != 4'd0);
   wire can_load = buf_full_q && (transmit_enable_bit || tx_busy);
   wire tx_load = shift_en && (tx_cnt_q <= 4'd1) && can_load;
   wire tx_done = shift_en && (tx_cnt_q == 4'd1) && !buf_full_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc_q <= 1'b0;
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
      end else begin
         // One stall cycle, then the request is taken
         acc_q <= req && !acc_q;
         waitrequest <= !(req && !acc_q);
         readdata <= (req && !acc_q && read) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stat_b_q <= ucft_pkg::RST_STAT_B;
         stat_c_q <= ucft_pkg::RST_STAT_C;
         dbl_q <= 1'b0;
         div_q <= ucft_pkg::RST_DIV;
      end else begin
         if (wr_a) dbl_q <= wd[ucft_pkg::A_DOUBLE];
         if (wr_b) stat_b_q <= {wd[7:2], 1'b0, wd[ucft_pkg::B_TX9]};
         if (wr_c) stat_c_q <= wd;
         if (wr_hi) div_q[11:8] <= wd[3:0];
         if (wr_lo) div_q[7:0] <= wd;
      end
   end

   // Transmit buffer and shifter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         buf_q <= 9'h000;
         buf_full_q <= 1'b0;
         sh_q <= '1;
         tx_cnt_q <= 4'd0;
         txd_o <= 1'b1;
         txd_oe <= 1'b0;
      end else begin
         if (tx_load) begin
            sh_q <= frame;
            txd_o <= 1'b0;
            tx_cnt_q <= frame_len;
            buf_full_q <= 1'b0;
         end else if (shift_en && tx_cnt_q > 4'd1) begin
            sh_q <= {1'b1, sh_q[ucft_pkg::FRAME_W-1:1]};
            txd_o <= sh_q[1];
            tx_cnt_q <= tx_cnt_q - 4'd1;
         end else if (shift_en) begin
            txd_o <= 1'b1;
            tx_cnt_q <= 4'd0;
         end
         // Ninth bit is taken from control B at the data write
         if (wr_data) begin
            buf_q <= {stat_b_q[ucft_pkg::B_TX9], wd};
            buf_full_q <= 1'b1;
         end
         // Disable waits for pending and ongoing frames
         txd_oe <= transmit_enable_bit || tx_busy || buf_full_q;
      end
   end

   // Complete flag: hardware set wins over a write-one clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         txcomp_q <= 1'b0;
      end else if (tx_done) begin
         txcomp_q <= 1'b1;
      end else if (wr_a && wd[ucft_pkg::A_TX_DONE]) begin
         txcomp_q <= 1'b0;
      end
   end

   // Clock generation
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ck_q <= 1'b0;
         tx_div_q <= 5'd0;
         tclk_o <= 1'b0;
         tclk_oe <= 1'b0;
      end else begin
         if (tick) ck_q <= !ck_q;
         if (tick) tx_div_q <= (tx_div_q >= bit_div - 5'd1) ? 5'd0 : tx_div_q + 5'd1;
         // Master clock runs free; the peer only looks at it within frames
         tclk_o <= tick ? !ck_q : ck_q;
         tclk_oe <= sync_mode && master;
      end
   end

   // Receiver: async samples mid-bit, sync samples on the sample edge
   wire rx_last = (rx_cnt_q == nbits + {3'b000, par_en} + 4'd1);
   wire async_smp = tick && (rx_ph_q == (bit_div >> 1));
   wire rx_smp = sync_mode ? sync_smp : async_smp;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_st_q <= ucft_pkg::RX_IDLE;
         rx_ph_q <= 5'd0;
         rx_cnt_q <= 4'd0;
         rx_sh_q <= 9'h000;
         rx_data_q <= 9'h000;
         ferr_q <= 1'b0;
         rxdone_q <= 1'b0;
      end else begin
         if (rd_data) rxdone_q <= 1'b0;
         if (tick) rx_ph_q <= (rx_ph_q >= bit_div - 5'd1) ? 5'd0 : rx_ph_q + 5'd1;
         case (rx_st_q)
            ucft_pkg::RX_IDLE: begin
               rx_cnt_q <= 4'd0;
               rx_sh_q <= 9'h000;
               if (rxen && !rxd_i && (sync_mode ? sync_smp : tick)) begin
                  rx_st_q <= ucft_pkg::RX_BUSY;
                  rx_ph_q <= 5'd1;
                  rx_cnt_q <= sync_mode ? 4'd1 : 4'd0;
               end
            end
            ucft_pkg::RX_BUSY: begin
               if (!rxen) begin
                  rx_st_q <= ucft_pkg::RX_IDLE;
               end else if (rx_smp) begin
                  rx_cnt_q <= rx_cnt_q + 4'd1;
                  if (rx_cnt_q == 4'd0 && rxd_i) rx_st_q <= ucft_pkg::RX_IDLE;
                  if (rx_cnt_q != 4'd0 && rx_cnt_q <= nbits) rx_sh_q[rx_cnt_q - 4'd1] <= rxd_i;
                  if (rx_last) begin
                     // Second stop bit is never examined
                     ferr_q <= !rxd_i;
                     rx_data_q <= rx_sh_q & size_mask(nbits);
                     rxdone_q <= 1'b1;
                     rx_st_q <= ucft_pkg::RX_IDLE;
                  end
               end
            end
            default: rx_st_q <= ucft_pkg::RX_IDLE;
         endcase
      end
   end
endmodule : ucft_top
`default_nettype wire

// file: src/ucft_pkg.sv
// Purpose: Shared constants for the serial transceiver clocking and framing block
// Assumes: 10 MHz system clock, Avalon-MM with 32-bit data, byte addresses
// Notes: Registers are 8 bits wide in the low byte of each word
`default_nettype none
package ucft_pkg;
   localparam logic [4:0] OFS_DATA = 5'h00;
   localparam logic [4:0] OFS_STAT_A = 5'h04;
   localparam logic [4:0] OFS_STAT_B = 5'h08;
   localparam logic [4:0] OFS_SHARED = 5'h0c;
   localparam logic [4:0] OFS_DIV_LO = 5'h10;
   // ctrl_status_a
   localparam int A_RX_DONE = 7;
   localparam int A_TX_DONE = 6;
   localparam int A_EMPTY = 5;
   localparam int A_FRAME_ERR = 4;
   localparam int A_DOUBLE = 1;
   // ctrl_status_b
   localparam int B_MASTER = 7;
   localparam int B_RXEN = 4;
   localparam int B_TX_ON = 3;
   localparam int B_SZ2 = 2;
   localparam int B_RX9 = 1;
   localparam int B_TX9 = 0;
   // ctrl_status_c
   localparam int C_SEL = 7;
   localparam int C_SYNC = 6;
   localparam int C_PAR_HI = 5;
   localparam int C_PAR_LO = 4;
   localparam int C_STOP2 = 3;
   localparam int C_SZ_HI = 2;
   localparam int C_SZ_LO = 1;
   localparam int C_POL = 0;
   localparam logic [7:0] RST_STAT_B = 8'h00;
   localparam logic [7:0] RST_STAT_C = 8'h06;
   localparam logic [11:0] RST_DIV = 12'h000;
   localparam logic [4:0] DIV_NORMAL = 5'h10;
   localparam logic [4:0] DIV_DOUBLE = 5'h08;
   localparam logic [2:0] SZ_NINE = 3'h7;
   localparam int FRAME_W = 13;
   typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} ucft_rx_st_t;
endpackage : ucft_pkg
`default_nettype wire

// file: src/ucft_baud_gen.sv
// Purpose: Baud down-counter producing one tick per reload
// Assumes: Divisor stable between writes
// Notes: Tick rate is clk / (divisor + 1)
`default_nettype none
module ucft_baud_gen (
   input wire logic clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic [11:0] divisor, // reload value
   input wire logic reload, // low byte written
   output logic tick // one-cycle tick
);
   logic [11:0] cnt_q;
   wire at_zero = (cnt_q == 12'h000);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 12'h000;
         tick <= 1'b0;
      end else begin
         cnt_q <= (at_zero || reload) ? divisor : cnt_q - 12'h001;
         tick <= at_zero || reload;
      end
   end
endmodule : ucft_baud_gen
`default_nettype wire

// file: src/ucft_clk_edge.sv
// Purpose: Synchronise the external transfer clock and detect its edges
// Assumes: Transfer clock below a quarter of the system clock
// Notes: Edge pulses appear two clocks after the pin changes
`default_nettype none
module ucft_clk_edge (
   input wire logic clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic tclk_i, // transfer clock pin level
   output logic rise, // rising edge pulse
   output logic fall // falling edge pulse
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= tclk_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
endmodule : ucft_clk_edge
`default_nettype wire

// file: verification/ucft_monitor.sv
// Purpose: Port-level checks on the transceiver top
// Assumes: One clock domain, async active-low reset
// Notes: Bit length floor of four clocks skips sync master
`default_nettype none
module ucft_monitor (
   input wire logic clk, // system clock
   input wire logic nrst, // async reset
   input wire logic [4:0] address, // byte address
   input wire logic read, // read request
   input wire logic write, // write request
   input wire logic [3:0] byteenable, // byte lanes
   input wire logic [31:0] writedata, // write data
   input wire logic [31:0] readdata, // read data
   input wire logic waitrequest, // slave stall
   input wire logic txd_o, // serial output
   input wire logic txd_oe, // serial enable
   input wire logic rxd_i, // serial input
   input wire logic tclk_i, // clock pin in
   input wire logic tclk_o, // clock pin out
   input wire logic tclk_oe // clock pin enable
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   wire unmapped = (address > 5'h10) || (address[1:0] != 2'h0);
   sequence req_s;
      (read || write) && waitrequest;
   endsequence
   sequence start_low_s;
      !txd_o [*4];
   endsequence
   wait_answer_a: assert property (req_s |=> !waitrequest) else $error("no answer after request");
   wait_single_a: assert property (!waitrequest |=> waitrequest) else $error("waitrequest low too long");
   rdata_idle_a: assert property (waitrequest |-> readdata == 32'h0) else $error("readdata not zero");
   rdata_byte_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0) else $error("upper readdata set");
   unmapped_zero_a: assert property (!waitrequest && read && unmapped |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   start_hold_a: assert property ($fell(txd_o) && !tclk_oe |-> start_low_s) else $error("bit too short");
   drive_low_a: assert property (!txd_o |-> txd_oe) else $error("low level without enable");
   release_high_a: assert property ($fell(txd_oe) |-> $past(txd_o)) else $error("released mid bit");
endmodule : ucft_monitor
`default_nettype wire

// file: verification/ucft_peer.sv
// Purpose: Remote serial peer decoding transmitted frames
// Assumes: Bit length in system clocks set by the bench
// Notes: Samples mid bit; a second stop bit is not examined
`default_nettype none
module ucft_peer (
   input wire logic clk, // system clock
   input wire logic txd, // line from transmitter
   input wire logic tclk_run, // drive the transfer clock
   input wire logic [4:0] bit_clks, // clocks per bit
   input wire logic [3:0] nbits, // data bits
   input wire logic par_en, // parity present
   output logic rxd, // line to receiver
   output logic tclk, // transfer clock for slave mode
   output logic [8:0] data, // last data
   output logic par, // last parity bit
   output logic stop, // last first stop bit
   output logic [7:0] frames // frames seen
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] ph_q = 3'h0;
   // Echo line: the receiver hears every frame sent, idle high
   assign rxd = txd;
   // Eight clocks a period, well under a quarter of clk
   always @(posedge clk) ph_q <= ph_q + 3'h1;
   assign tclk = tclk_run & ph_q[2];
   initial begin
      logic [8:0] d;
      frames = 8'h00;
      data = 9'h000;
      par = 1'b0;
      stop = 1'b0;
      forever begin
         @(negedge txd);
         repeat (bit_clks / 2) @(posedge clk);
         d = 9'h000;
         for (int i = 0; i < nbits; i++) begin
            repeat (bit_clks) @(posedge clk);
            d[i] = txd;
         end
         if (par_en) begin
            repeat (bit_clks) @(posedge clk);
            par = txd;
         end
         repeat (bit_clks) @(posedge clk);
         stop = txd;
         data = d;
         frames = frames + 8'h01;
      end
   end
endmodule : ucft_peer
`default_nettype wire

// file: verification/tb_ucft_top.sv
// Purpose: Register and serial frame tests of the transceiver
// Assumes: Divisor zero, so one bit is 16 or 8 clocks
// Notes: Receiver hears the transmitter through the peer's echo
`default_nettype none
module tb_ucft_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, nrst, read, write, waitrequest, txd_o, txd_oe, rxd_i, tclk_o, tclk_oe, par_en, got_par, got_stop;
   logic tclk, tclk_run;
   logic [4:0] address, bit_clks;
   logic [3:0] byteenable, nbits;
   logic [31:0] writedata, readdata;
   logic [8:0] got_data, m;
   logic [7:0] frames, rd;
   int errors, checks_done, cycles, n;
   logic [7:0] f_c [5] = '{8'h86, 8'ha8, 8'hb4, 8'ha6, 8'h82};
   logic [7:0] f_b [5] = '{8'h18, 8'h18, 8'h18, 8'h1d, 8'h18};
   logic [8:0] f_d [5] = '{9'h055, 9'h0f3, 9'h0a6, 9'h181, 9'h0ea};
   logic [3:0] f_n [5] = '{4'h8, 4'h5, 4'h7, 4'h9, 4'h6};
   logic f_x [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   ucft_top u_ucft_top (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .txd_o(txd_o), .txd_oe(txd_oe), .rxd_i(rxd_i), .tclk_i(tclk), .tclk_o(tclk_o), .tclk_oe(tclk_oe));
   ucft_peer u_ucft_peer (.clk(clk), .txd(txd_o), .tclk_run(tclk_run), .bit_clks(bit_clks), .nbits(nbits),
      .par_en(par_en), .rxd(rxd_i), .tclk(tclk), .data(got_data), .par(got_par), .stop(got_stop),
      .frames(frames));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic complete_run;
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   task automatic chk_ser(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_ser
   task automatic chk_reg(input logic [7:0] exp);
      chk_ser({1'b0, rd}, {1'b0, exp});
   endtask : chk_reg
   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      address <= a;
      writedata <= {24'h0, d};
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata[7:0];
      write <= 1'b0;
      read <= 1'b0;
   endtask : bus
   task automatic wait_frame;
      int k;
      logic [7:0] t;
      k = 0;
      t = frames + 8'h01;
      while (frames !== t && k < 3000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 3000) errors++;
   endtask : wait_frame
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      nrst = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 5'h00;
      byteenable = 4'h1;
      writedata = 32'h0;
      bit_clks = 5'h10;
      nbits = 4'h8;
      par_en = 1'b0;
      tclk_run = 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      bus(0, ucft_pkg::OFS_STAT_B, 8'h00); chk_reg(ucft_pkg::RST_STAT_B);
      bus(0, ucft_pkg::OFS_SHARED, 8'h00); chk_reg(ucft_pkg::RST_STAT_C);
      bus(0, ucft_pkg::OFS_STAT_A, 8'h00); chk_reg(8'h20);
      bus(1, 5'h14, 8'hff);
      bus(0, 5'h14, 8'h00); chk_reg(8'h00);
      bus(1, ucft_pkg::OFS_SHARED, 8'h03);
      bus(0, ucft_pkg::OFS_SHARED, 8'h00); chk_reg(ucft_pkg::RST_STAT_C);
      bus(1, ucft_pkg::OFS_SHARED, 8'h00);
      bus(1, ucft_pkg::OFS_DIV_LO, 8'h00);
      for (int i = 0; i < 5; i++) begin
         bit_clks <= f_x[i] ? 5'h08 : 5'h10;
         nbits <= f_n[i];
         par_en <= f_c[i][5];
         bus(1, ucft_pkg::OFS_STAT_A, {6'h10, f_x[i], 1'b0});
         bus(1, ucft_pkg::OFS_SHARED, f_c[i]);
         bus(1, ucft_pkg::OFS_STAT_B, f_b[i]);
         bus(1, ucft_pkg::OFS_DATA, f_d[i][7:0]);
         wait_frame();
         m = f_d[i] & ((9'h001 << f_n[i]) - 9'h001);
         chk_ser(got_data, m);
         if (f_c[i][5]) chk_ser({8'h0, got_par}, {8'h0, ^m ^ f_c[i][4]});
         chk_ser({8'h0, got_stop}, 9'h001);
         repeat (48) @(posedge clk);
         bus(0, ucft_pkg::OFS_STAT_A, 8'h00); chk_reg({6'h38, f_x[i], 1'b0});
         bus(0, ucft_pkg::OFS_DATA, 8'h00); chk_reg(m[7:0]);
      end
      // Second write lands while the first frame shifts
      bit_clks <= 5'h10;
      nbits <= 4'h8;
      par_en <= 1'b0;
      bus(1, ucft_pkg::OFS_STAT_A, 8'h40);
      bus(1, ucft_pkg::OFS_SHARED, 8'h86);
      bus(1, ucft_pkg::OFS_DATA, 8'h33);
      n = 0;
      while (txd_o !== 1'b0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      bus(1, ucft_pkg::OFS_DATA, 8'hcc);
      bus(0, ucft_pkg::OFS_STAT_A, 8'h00); chk_reg(8'h00);
      wait_frame();
      chk_ser(got_data, 9'h033);
      wait_frame();
      chk_ser(got_data, 9'h0cc);
      // Disable lets the last stop bit finish, then frees the pin
      bus(1, ucft_pkg::OFS_STAT_B, 8'h00);
      repeat (32) @(posedge clk);
      chk_ser({8'h0, txd_oe}, 9'h000);
      // Slave: the peer supplies an eight-clock transfer clock
      tclk_run <= 1'b1;
      bit_clks <= 5'h08;
      bus(1, ucft_pkg::OFS_STAT_A, 8'h40);
      bus(1, ucft_pkg::OFS_SHARED, 8'hc6);
      bus(1, ucft_pkg::OFS_STAT_B, 8'h18);
      bus(1, ucft_pkg::OFS_DATA, 8'h5a);
      wait_frame();
      chk_ser(got_data, 9'h05a);
      bus(0, ucft_pkg::OFS_DATA, 8'h00); chk_reg(8'h5a);
      tclk_run <= 1'b0;
      bus(1, ucft_pkg::OFS_STAT_B, 8'h88);
      repeat (2) @(posedge clk);
      chk_ser({8'h0, tclk_oe}, 9'h001);
      m = {8'h0, tclk_o};
      @(posedge clk);
      chk_ser({8'h0, tclk_o}, m ^ 9'h001);
      complete_run();
   end
endmodule : tb_ucft_top
bind ucft_top ucft_monitor u_ucft_monitor (.clk(clk), .nrst(nrst), .address(address), .read(read),
   .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .txd_o(txd_o), .txd_oe(txd_oe), .rxd_i(rxd_i), .tclk_i(tclk_i),
   .tclk_o(tclk_o), .tclk_oe(tclk_oe));
`default_nettype wire
